// >>> core/fcp_core.sv
// Configuration, test and sector protection registers of a two-block flash
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Test register reads zero, ignores writes normally
// - write_all_banks writable only in special mode
// - write_all_banks writes every bank, else selected
// - Config keeps four bits; others read zero
// - Key write enable writable only if keys enabled
// - Buffer empty interrupt follows flag and enable
// - Command done interrupt follows flag and enable
// - Key mode turns array writes into keys
// - bank_select picks block zero or one bank
// - Protection bits writable except read-only bit six
// - Protection bytes loaded from nonvolatile at reset
// - Protected program or erase refused, violation set
// - Mass erase refused if anything protected
// - protect_open_select sets protect versus unprotect meaning
// - high_range_disable enables high area when zero
// - high_range_size writable only while high disabled
// - low_range_disable enables low area when zero
// - low_range_size writable only while low disabled
// - Both disabled: none or full block protection
// - Only key encoding 10 enables backdoor
// - Invalid scenario transitions ignored, register unchanged
// - High sizes 2 to 16 Kbytes below 0xFFFF
// - Low sizes 1 to 8 Kbytes from 0x4000
module fcp_core
  import fcp_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        ce_in,
  // Register port
  input  wire logic [3:0]  addr_in,
  input  wire logic [7:0]  wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [7:0]  rdata_out,
  // Chip mode pin
  input  wire logic        special_mode_in,
  // Nonvolatile load at end of reset sequence
  input  wire logic        nv_load_in,
  input  wire logic [7:0]  nv_prot_blk0_in,
  input  wire logic [7:0]  nv_prot_blk1_in,
  input  wire logic [1:0]  nv_backdoor_key_enable_in,
  // Command status flags
  input  wire logic        cmd_buf_empty_flag_in,
  input  wire logic        cmd_done_flag_in,
  output logic             cbe_irq_out,
  output logic             done_irq_out,
  // Program and erase check
  input  wire logic        cmd_valid_in,
  input  wire logic        cmd_mass_in,
  input  wire logic        cmd_block_in,
  input  wire logic [15:0] cmd_addr_in,
  output logic             cmd_grant_out,
  output logic             cmd_refuse_out,
  // Flash array accesses
  input  wire logic        array_wr_in,
  input  wire logic        array_rd_in,
  output logic             array_cmd_start_out,
  output logic             array_key_out,
  output logic             array_rd_invalid_out
);

  // ==========================================================================
  // State
  logic            mode_meta;
  logic            special_q;
  logic            write_all_banks;
  logic            cmd_buf_empty_irq_en;
  logic            cmd_done_irq_en;
  logic            backdoor_key_write_en;
  logic            bank_select;
  logic [1:0]      backdoor_key_enable;
  fcp_prot_t       sector_protection [2];
  logic [1:0]      protect_violation_flag;
  logic            cmd_blk_q;

  logic            wr_test;
  logic            wr_cfg;
  logic            wr_prot;
  logic            wr_stat;
  logic [1:0]      bank_hit;
  logic [1:0]      prot_take;
  fcp_prot_t       next_prot [2];
  fcp_prot_t       prot_sel;
  fcp_prot_t       prot_cmd;
  logic            key_ok;
  logic            in_high;
  logic            in_low;
  logic            addr_prot;
  logic            any_prot;
  logic            refuse;

  assign wr_test = wr_in && (addr_in == FCP_REG_TEST);
  assign wr_cfg  = wr_in && (addr_in == FCP_REG_CFG);
  assign wr_prot = wr_in && (addr_in == FCP_REG_PROT);
  assign wr_stat = wr_in && (addr_in == FCP_REG_STAT);
  assign key_ok  = (backdoor_key_enable == FCP_BACKDOOR_KEY_ENABLE_ENABLE);

  // ==========================================================================
  // Mode pin synchroniser
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mode_meta <= 1'b0;
      special_q <= 1'b0;
    end else if (ce_in) begin
      mode_meta <= special_mode_in;
      special_q <= mode_meta;
    end
  end

  // ==========================================================================
  // Test register: only write_all_banks exists, and only in special mode
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      write_all_banks <= 1'b0;
    end else if (ce_in) begin
      if (!special_q) begin
        write_all_banks <= 1'b0;
      end else if (wr_test) begin
        write_all_banks <= wdata_in[FCP_TEST_WRITE_ALL_BANKS];
      end
    end
  end

  // ==========================================================================
  // Configuration register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cmd_buf_empty_irq_en  <= 1'b0;
      cmd_done_irq_en       <= 1'b0;
      backdoor_key_write_en <= 1'b0;
      bank_select           <= 1'b0;
    end else if (ce_in && wr_cfg) begin
      cmd_buf_empty_irq_en <= wdata_in[FCP_CFG_CMD_BUF_EMPTY_IRQ_EN];
      cmd_done_irq_en      <= wdata_in[FCP_CFG_CMD_DONE_IRQ_EN];
      bank_select          <= wdata_in[FCP_CFG_BANK];
      if (key_ok) begin
        backdoor_key_write_en <= wdata_in[FCP_CFG_KEY];
      end
    end
  end

  // ==========================================================================
  // Banked protection registers
  // A bank takes a write if it is selected or if all banks are written
  assign bank_hit[0] = write_all_banks || !bank_select;
  assign bank_hit[1] = write_all_banks || bank_select;

  // Sizes move only while their range is disabled; bit six never moves
  always_comb begin
    for (int b = 0; b < 2; b++) begin
      next_prot[b]                 = fcp_prot_t'(wdata_in);
      next_prot[b].reserved_nv_bit = sector_protection[b].reserved_nv_bit;
      if (!sector_protection[b].high_dis) begin
        next_prot[b].high_size = sector_protection[b].high_size;
      end
      if (!sector_protection[b].low_dis) begin
        next_prot[b].low_size = sector_protection[b].low_size;
      end
      // Scenario code is {open, high disable, low disable}
      prot_take[b] = FCP_SCN_ALLOWED[{
        sector_protection[b].open_sel, sector_protection[b].high_dis,
        sector_protection[b].low_dis, next_prot[b].open_sel,
        next_prot[b].high_dis, next_prot[b].low_dis}];
    end
  end

  // Key enable is held here since the security register is kept elsewhere
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      backdoor_key_enable <= FCP_BACKDOOR_KEY_ENABLE_RESET;
    end else if (ce_in && nv_load_in) begin
      backdoor_key_enable <= nv_backdoor_key_enable_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sector_protection[0] <= fcp_prot_t'(FCP_PROT_RESET);
      sector_protection[1] <= fcp_prot_t'(FCP_PROT_RESET);
    end else if (ce_in) begin
      if (nv_load_in) begin
        sector_protection[0] <= fcp_prot_t'(nv_prot_blk0_in);
        sector_protection[1] <= fcp_prot_t'(nv_prot_blk1_in);
      end else if (wr_prot) begin
        for (int b = 0; b < 2; b++) begin
          if (bank_hit[b] && prot_take[b]) begin
            sector_protection[b] <= next_prot[b];
          end
        end
      end
    end
  end

  // ==========================================================================
  // Address check against the addressed block's protection
  assign prot_cmd  = sector_protection[cmd_block_in];
  assign prot_sel  = sector_protection[bank_select];

  always_comb begin
    in_high = 1'b0;
    if (!prot_cmd.high_dis) begin
      case (prot_cmd.high_size)
        2'b00:   in_high = (cmd_addr_in >= FCP_HI_BASE0);
        2'b01:   in_high = (cmd_addr_in >= FCP_HI_BASE1);
        2'b10:   in_high = (cmd_addr_in >= FCP_HI_BASE2);
        default: in_high = (cmd_addr_in >= FCP_HI_BASE3);
      endcase
    end
    in_low = 1'b0;
    if (!prot_cmd.low_dis && (cmd_addr_in >= FCP_LO_BASE)) begin
      case (prot_cmd.low_size)
        2'b00:   in_low = (cmd_addr_in <= FCP_LO_LAST0);
        2'b01:   in_low = (cmd_addr_in <= FCP_LO_LAST1);
        2'b10:   in_low = (cmd_addr_in <= FCP_LO_LAST2);
        default: in_low = (cmd_addr_in <= FCP_LO_LAST3);
      endcase
    end
  end

  // Open mode protects the ranges, closed mode protects all but them
  assign addr_prot = prot_cmd.open_sel ? (in_high || in_low)
                                       : !(in_high || in_low);
  // Closed mode always leaves part of the block protected
  assign any_prot  = !prot_cmd.open_sel || !prot_cmd.high_dis
                     || !prot_cmd.low_dis;
  assign refuse    = cmd_mass_in ? any_prot : addr_prot;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cmd_grant_out  <= 1'b0;
      cmd_refuse_out <= 1'b0;
      cmd_blk_q      <= 1'b0;
    end else if (ce_in) begin
      cmd_grant_out  <= cmd_valid_in && !refuse;
      cmd_refuse_out <= cmd_valid_in && refuse;
      cmd_blk_q      <= cmd_block_in;
    end
  end

  // Violation flags: write one to clear, a new violation wins the clear
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      protect_violation_flag <= 2'b00;
    end else if (ce_in) begin
      for (int b = 0; b < 2; b++) begin
        if (cmd_valid_in && refuse && (cmd_block_in == b[0])) begin
          protect_violation_flag[b] <= 1'b1;
        end else if (wr_stat && bank_hit[b] && wdata_in[FCP_STAT_VIOL]) begin
          protect_violation_flag[b] <= 1'b0;
        end
      end
    end
  end

  // ==========================================================================
  // Interrupt requests and array access steering
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cbe_irq_out  <= 1'b0;
      done_irq_out <= 1'b0;
    end else if (ce_in) begin
      cbe_irq_out  <= cmd_buf_empty_irq_en && cmd_buf_empty_flag_in;
      done_irq_out <= cmd_done_irq_en && cmd_done_flag_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      array_cmd_start_out  <= 1'b0;
      array_key_out        <= 1'b0;
      array_rd_invalid_out <= 1'b0;
    end else if (ce_in) begin
      array_cmd_start_out  <= array_wr_in && !backdoor_key_write_en;
      array_key_out        <= array_wr_in && backdoor_key_write_en;
      array_rd_invalid_out <= array_rd_in && backdoor_key_write_en;
    end
  end

  // ==========================================================================
  // Read port; unmapped indexes read zero
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_out <= FCP_ZERO8;
    end else if (ce_in) begin
      rdata_out <= FCP_ZERO8;
      if (rd_in) begin
        if (addr_in == FCP_REG_TEST) begin
          rdata_out[FCP_TEST_WRITE_ALL_BANKS] <= write_all_banks;
        end else if (addr_in == FCP_REG_CFG) begin
          rdata_out[FCP_CFG_CMD_BUF_EMPTY_IRQ_EN] <= cmd_buf_empty_irq_en;
          rdata_out[FCP_CFG_CMD_DONE_IRQ_EN]  <= cmd_done_irq_en;
          rdata_out[FCP_CFG_KEY]   <= backdoor_key_write_en;
          rdata_out[FCP_CFG_BANK]  <= bank_select;
        end else if (addr_in == FCP_REG_PROT) begin
          rdata_out <= prot_sel;
        end else if (addr_in == FCP_REG_STAT) begin
          rdata_out[FCP_STAT_CBE]  <= cmd_buf_empty_flag_in;
          rdata_out[FCP_STAT_DONE] <= cmd_done_flag_in;
          rdata_out[FCP_STAT_VIOL] <= protect_violation_flag[bank_select];
        end
      end
    end
  end

  // ==========================================================================
  // Checks
  default clocking fcp_cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  sequence mass_req_s;
    ce_in && cmd_valid_in && cmd_mass_in && any_prot;
  endsequence

  sequence refuse_seen_s;
    ce_in && cmd_refuse_out;
  endsequence

  test_normal_zero_a: assert property (
    ce_in && !special_q |=> !write_all_banks)
    else $error("test register bit set in normal mode");

  key_gate_a: assert property (
    ce_in && wr_cfg && !key_ok |=> $stable(backdoor_key_write_en))
    else $error("key write enable changed while keys disabled");

  cbe_irq_a: assert property (
    ce_in |=> cbe_irq_out == $past(cmd_buf_empty_irq_en
                                   && cmd_buf_empty_flag_in))
    else $error("buffer empty interrupt wrong");

  done_irq_a: assert property (
    ce_in && cmd_done_flag_in && !cmd_done_irq_en |=> !done_irq_out)
    else $error("command done interrupt not suppressed");

  mass_refuse_a: assert property (
    mass_req_s |=> cmd_refuse_out && !cmd_grant_out)
    else $error("mass erase granted on protected block");

  violation_set_a: assert property (
    refuse_seen_s |-> protect_violation_flag[cmd_blk_q])
    else $error("refused command left no violation flag");

  reserved_ro_a: assert property (
    ce_in && wr_prot && !nv_load_in |=>
      $stable(sector_protection[0].reserved_nv_bit))
    else $error("reserved protection bit was written");

  high_size_lock_a: assert property (
    ce_in && !nv_load_in && !sector_protection[1].high_dis |=>
      $stable(sector_protection[1].high_size))
    else $error("high size moved while range enabled");

  key_array_a: assert property (
    ce_in && array_rd_in && backdoor_key_write_en ##1 ce_in |->
      array_rd_invalid_out ##0 !array_cmd_start_out[*1])
    else $error("array read in key mode not marked invalid");

  bank_read_a: assert property (
    ce_in && rd_in && (addr_in == FCP_REG_PROT) |=>
      rdata_out == $past(bank_select ? sector_protection[1]
                                     : sector_protection[0]))
    else $error("protection read from wrong bank");

endmodule

`default_nettype wire

// >>> include/fcp_pkg.sv
// Constants, register map and types of the flash configuration and protection block
package fcp_pkg;

  // ==========================================================================
  // Register map (index on the register port)
  localparam logic [3:0] FCP_REG_TEST = 4'h2;
  localparam logic [3:0] FCP_REG_CFG  = 4'h3;
  localparam logic [3:0] FCP_REG_PROT = 4'h4;
  localparam logic [3:0] FCP_REG_STAT = 4'h5;

  // ==========================================================================
  // Field positions
  localparam int unsigned FCP_TEST_WRITE_ALL_BANKS   = 4;
  localparam int unsigned FCP_CFG_CMD_BUF_EMPTY_IRQ_EN    = 7;
  localparam int unsigned FCP_CFG_CMD_DONE_IRQ_EN     = 6;
  localparam int unsigned FCP_CFG_KEY      = 5;
  localparam int unsigned FCP_CFG_BANK     = 0;
  localparam int unsigned FCP_STAT_CBE     = 7;
  localparam int unsigned FCP_STAT_DONE    = 6;
  localparam int unsigned FCP_STAT_VIOL    = 5;

  // ==========================================================================
  // Reset and nonvolatile values
  localparam logic [7:0]  FCP_ZERO8        = 8'h00;
  localparam logic [7:0]  FCP_PROT_RESET   = 8'hFF;
  localparam logic [1:0]  FCP_BACKDOOR_KEY_ENABLE_ENABLE = 2'b10;
  localparam logic [1:0]  FCP_BACKDOOR_KEY_ENABLE_RESET  = 2'b01;
  localparam logic [15:0] FCP_NV_PROT_BLK0 = 16'hFF0D;
  localparam logic [15:0] FCP_NV_PROT_BLK1 = 16'hFF0C;

  // ==========================================================================
  // Range limits: high ranges end at the top, low ranges start at the base
  localparam logic [15:0] FCP_HI_BASE0 = 16'hF800;
  localparam logic [15:0] FCP_HI_BASE1 = 16'hF000;
  localparam logic [15:0] FCP_HI_BASE2 = 16'hE000;
  localparam logic [15:0] FCP_HI_BASE3 = 16'hC000;
  localparam logic [15:0] FCP_LO_BASE  = 16'h4000;
  localparam logic [15:0] FCP_LO_LAST0 = 16'h43FF;
  localparam logic [15:0] FCP_LO_LAST1 = 16'h47FF;
  localparam logic [15:0] FCP_LO_LAST2 = 16'h4FFF;
  localparam logic [15:0] FCP_LO_LAST3 = 16'h5FFF;

  // ==========================================================================
  // Allowed scenario transitions, one row per source scenario {open,hdis,ldis}
  localparam logic [63:0] FCP_SCN_ALLOWED = 64'hFF5A_3C18_080C_0A0F;

  // Protection register layout
  typedef struct packed {
    logic       open_sel;
    logic       reserved_nv_bit;
    logic       high_dis;
    logic [1:0] high_size;
    logic       low_dis;
    logic [1:0] low_size;
  } fcp_prot_t;

endpackage

// >>> testbench/fcp_testbench.sv
// Self-checking testbench of the flash configuration and protection block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import fcp_pkg::*;
  // ==========================================================================
  // Design signals
  logic        clk_in;
  logic        rst_in;
  logic        ce_in;
  logic [3:0]  addr_in;
  logic [7:0]  wdata_in;
  logic        wr_in;
  logic        rd_in;
  logic [7:0]  rdata_out;
  logic        special_mode_in;
  logic        nv_load_in;
  logic [7:0]  nv_prot_blk0_in;
  logic [7:0]  nv_prot_blk1_in;
  logic [1:0]  nv_backdoor_key_enable_in;
  logic        cmd_buf_empty_flag_in;
  logic        cmd_done_flag_in;
  logic        cbe_irq_out;
  logic        done_irq_out;
  logic        cmd_valid_in;
  logic        cmd_mass_in;
  logic        cmd_block_in;
  logic [15:0] cmd_addr_in;
  logic        cmd_grant_out;
  logic        cmd_refuse_out;
  logic        array_wr_in;
  logic        array_rd_in;
  logic        array_cmd_start_out;
  logic        array_key_out;
  logic        array_rd_invalid_out;
  int          err_count;
  int          total_checks;
  int          cycles = 0;
  localparam int LIMIT = 3000;
  // Allowed scenario changes, one row per source {open,high_dis,low_dis}
  localparam logic [7:0] SCN_OK [8] = '{8'h0F, 8'h0A, 8'h0C, 8'h08,
                                        8'h18, 8'h3C, 8'h5A, 8'hFF};
  // Rows: block, mass, address, refusal expected
  localparam logic [18:0] ROWS [9] = '{
    {1'b0, 1'b0, 16'h4000, 1'b0}, {1'b0, 1'b0, 16'h47FF, 1'b0},
    {1'b0, 1'b0, 16'h4800, 1'b1}, {1'b0, 1'b0, 16'hFFFF, 1'b1},
    {1'b0, 1'b1, 16'h0000, 1'b1}, {1'b1, 1'b0, 16'hBFFF, 1'b0},
    {1'b1, 1'b0, 16'hC000, 1'b1}, {1'b1, 1'b0, 16'h4000, 1'b0},
    {1'b1, 1'b1, 16'h0000, 1'b1}};

  fcp_core u_dut (
    .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
    .rd_in(rd_in), .rdata_out(rdata_out),
    .special_mode_in(special_mode_in), .nv_load_in(nv_load_in),
    .nv_prot_blk0_in(nv_prot_blk0_in), .nv_prot_blk1_in(nv_prot_blk1_in),
    .nv_backdoor_key_enable_in(nv_backdoor_key_enable_in),
    .cmd_buf_empty_flag_in(cmd_buf_empty_flag_in),
    .cmd_done_flag_in(cmd_done_flag_in),
    .cbe_irq_out(cbe_irq_out), .done_irq_out(done_irq_out),
    .cmd_valid_in(cmd_valid_in), .cmd_mass_in(cmd_mass_in),
    .cmd_block_in(cmd_block_in), .cmd_addr_in(cmd_addr_in),
    .cmd_grant_out(cmd_grant_out), .cmd_refuse_out(cmd_refuse_out),
    .array_wr_in(array_wr_in), .array_rd_in(array_rd_in),
    .array_cmd_start_out(array_cmd_start_out),
    .array_key_out(array_key_out),
    .array_rd_invalid_out(array_rd_invalid_out));

  // ==========================================================================
  // Clock and hang guard
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      err_count = err_count + 1;
      $display("ERROR %0t: run did not finish in time", $time);
      stop_test();
    end
  end

  // ==========================================================================
  // Compare and bus tasks
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("ERROR %0t: byte got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("ERROR %0t: bit got %b expected %b", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr_in    <= 1'b1;
    addr_in  <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in    <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    rd_in   <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in   <= 1'b0;
    #1;
    chk8(rdata_out, exp);
  endtask

  task automatic reset_dut(input int n);
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (n) @(posedge clk_in);
    rst_in <= 1'b0;
  endtask

  task automatic nv_load();
    @(posedge clk_in);
    nv_load_in <= 1'b1;
    @(posedge clk_in);
    nv_load_in <= 1'b0;
  endtask

  task automatic cmd(input logic b, input logic m, input logic [15:0] a,
                     input logic refuse);
    @(posedge clk_in);
    cmd_valid_in <= 1'b1;
    cmd_block_in <= b;
    cmd_mass_in  <= m;
    cmd_addr_in  <= a;
    @(posedge clk_in);
    cmd_valid_in <= 1'b0;
    #1;
    chk1(cmd_refuse_out, refuse);
    chk1(cmd_grant_out, !refuse);
  endtask

  task automatic arr(input logic is_rd, input logic key);
    @(posedge clk_in);
    array_wr_in <= !is_rd;
    array_rd_in <= is_rd;
    @(posedge clk_in);
    array_wr_in <= 1'b0;
    array_rd_in <= 1'b0;
    #1;
    if (is_rd) begin
      chk1(array_rd_invalid_out, key);
    end else begin
      chk1(array_key_out, key);
      chk1(array_cmd_start_out, !key);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin : main
    logic [7:0] e;
    logic [2:0] sv;
    logic [2:0] tv;
    logic       key;
    err_count = 0;
    total_checks = 0;
    rst_in = 1'b1;
    ce_in = 1'b1;
    addr_in = 4'h0;
    wdata_in = 8'h00;
    wr_in = 1'b0;
    rd_in = 1'b0;
    special_mode_in = 1'b0;
    nv_load_in = 1'b0;
    nv_prot_blk0_in = 8'hFF;
    nv_prot_blk1_in = 8'hDE;
    nv_backdoor_key_enable_in = 2'b01;
    cmd_buf_empty_flag_in = 1'b0;
    cmd_done_flag_in = 1'b0;
    cmd_valid_in = 1'b0;
    cmd_mass_in = 1'b0;
    cmd_block_in = 1'b0;
    cmd_addr_in = 16'h0000;
    array_wr_in = 1'b0;
    array_rd_in = 1'b0;
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(FCP_REG_PROT, 8'hFF);
    rd(FCP_REG_CFG, 8'h00);
    rd(4'hF, 8'h00);
    wr(FCP_REG_TEST, 8'h10);
    rd(FCP_REG_TEST, 8'h00);
    nv_load();
    rd(FCP_REG_PROT, 8'hFF);
    wr(FCP_REG_CFG, 8'h01);
    rd(FCP_REG_PROT, 8'hDE);
    wr(FCP_REG_CFG, 8'h00);
    // Size fields move only because the old disable bits were set
    wr(FCP_REG_PROT, 8'h61);
    rd(FCP_REG_PROT, 8'h61);
    for (int i = 0; i < 9; i++) begin
      cmd(ROWS[i][18], ROWS[i][17], ROWS[i][16:1], ROWS[i][0]);
    end
    rd(FCP_REG_STAT, 8'h20);
    wr(FCP_REG_STAT, 8'h20);
    rd(FCP_REG_STAT, 8'h00);
    wr(FCP_REG_CFG, 8'h01);
    rd(FCP_REG_STAT, 8'h20);
    $display("test commands done");
    special_mode_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    wr(FCP_REG_TEST, 8'h10);
    rd(FCP_REG_TEST, 8'h10);
    wr(FCP_REG_PROT, 8'h3F);
    rd(FCP_REG_PROT, 8'h7F);
    wr(FCP_REG_CFG, 8'h00);
    rd(FCP_REG_PROT, 8'h7D);
    special_mode_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    rd(FCP_REG_TEST, 8'h00);
    $display("test write all banks done");
    for (int i = 0; i < 8; i++) begin
      wr(FCP_REG_CFG, {i[0], i[1], 6'h00});
      cmd_buf_empty_flag_in <= i[2];
      cmd_done_flag_in <= i[2];
      repeat (2) @(posedge clk_in);
      #1;
      chk1(cbe_irq_out, i[0] & i[2]);
      chk1(done_irq_out, i[1] & i[2]);
      rd(FCP_REG_STAT, {i[2], i[2], 6'h00});
    end
    cmd_buf_empty_flag_in <= 1'b0;
    cmd_done_flag_in <= 1'b0;
    $display("test interrupts done");
    for (int k = 0; k < 4; k++) begin
      key = (k == 2);
      reset_dut(1);
      nv_backdoor_key_enable_in <= k[1:0];
      nv_load();
      wr(FCP_REG_CFG, 8'hFF);
      rd(FCP_REG_CFG, {2'b11, key, 4'h0, 1'b1});
      arr(1'b0, key);
      arr(1'b1, key);
    end
    $display("test key access done");
    // A write while the clock enable is low must leave the register alone
    ce_in <= 1'b0;
    wr(FCP_REG_CFG, 8'h00);
    ce_in <= 1'b1;
    rd(FCP_REG_CFG, 8'hC1);
    $display("test clock enable done");
    for (int s = 0; s < 8; s++) begin
      for (int t = 0; t < 8; t++) begin
        sv = s[2:0];
        tv = t[2:0];
        reset_dut(1);
        nv_prot_blk0_in <= {sv[2], 1'b1, sv[1], 2'b10, sv[0], 2'b01};
        nv_load();
        wr(FCP_REG_PROT, {tv[2], 1'b0, tv[1], 2'b01, tv[0], 2'b10});
        if (SCN_OK[s][t]) begin
          e = {tv[2], 1'b1, tv[1], sv[1] ? 2'b01 : 2'b10,
               tv[0], sv[0] ? 2'b10 : 2'b01};
        end else begin
          e = {sv[2], 1'b1, sv[1], 2'b10, sv[0], 2'b01};
        end
        rd(FCP_REG_PROT, e);
        cmd(1'b0, 1'b1, 16'h0000, !(e[7] & e[5] & e[2]));
      end
    end
    $display("test protection transitions done");
    stop_test();
  end
endmodule
`default_nettype wire
